// [core/nic_cmd_pkg.sv]
package nic_cmd_pkg;

  localparam logic [3:0] core_command_index = 4'h0;
  localparam logic [3:0] event_status_index = 4'h7;

  localparam int halt_pos = 0;
  localparam int run_pos = 1;
  localparam int txreq_pos = 2;
  localparam int rdma_lsb = 3;
  localparam int page_lsb = 6;
  localparam int reset_flag_pos = 7;

  typedef enum logic [1:0] {
    page_zero = 2'b00,
    page_one = 2'b01,
    page_two = 2'b10,
    page_reserved = 2'b11
  } page_t;

  typedef enum logic [2:0] {
    rdma_illegal = 3'b000,
    rdma_read = 3'b001,
    rdma_write = 3'b010,
    rdma_send = 3'b011,
    rdma_abort = 3'b100
  } rdma_code_t;

  typedef enum logic [1:0] {
    core_reset = 2'b00,
    core_running = 2'b01,
    core_draining = 2'b10
  } core_state_t;

  typedef enum logic [1:0] {
    dma_idle = 2'b00,
    dma_reading = 2'b01,
    dma_writing = 2'b10,
    dma_sending = 2'b11
  } dma_state_t;

  typedef struct packed {
    page_t page;
    logic [2:0] rdma_cmd;
    logic transmit_request;
    logic run_bit;
    logic halt_bit;
  } core_command_t;

  localparam core_command_t command_reset_value = '{
    page: page_zero,
    rdma_cmd: rdma_abort,
    transmit_request: 1'b0,
    run_bit: 1'b0,
    halt_bit: 1'b1
  };

  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [3:0] index;
    logic [7:0] wdata;
  } host_access_t;

endpackage

// [core/page_decode.sv]
`timescale 1ns/100ps
`default_nettype none
module page_decode (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire nic_cmd_pkg::page_t page,
  input wire nic_cmd_pkg::host_access_t access,
  output logic [3:0] sel_index,
  output logic [1:0] sel_page,
  output logic sel_rd,
  output logic sel_wr
);

  logic [3:0] next_sel_index;
  logic [1:0] next_sel_page;
  logic next_sel_rd;
  logic next_sel_wr;
  logic cmd_hit;

  // The command register shows in every page, so it is never forwarded.
  always_comb begin
    cmd_hit = access.index == nic_cmd_pkg::core_command_index;
    next_sel_index = access.index;
    next_sel_page = page;
    next_sel_rd = access.cs && access.rd && !cmd_hit;
    next_sel_wr = access.cs && access.wr && !cmd_hit;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_index <= 4'h0;
      sel_page <= 2'h0;
      sel_rd <= 1'b0;
      sel_wr <= 1'b0;
    end else begin
      sel_index <= next_sel_index;
      sel_page <= next_sel_page;
      sel_rd <= next_sel_rd;
      sel_wr <= next_sel_wr;
    end
  end

endmodule // page_decode
`default_nettype wire

// [core/nic_command_register.sv]
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Page bits pick register page reached
// - DMA field: read, write, send, abort
// - Halt drains activity then enters reset
// - Leave reset only when halt clear, run set
// - Reset done shown by reset-status flag
// - Halt bit powers up set
// - Run bit powers up clear, starts core
// - Halt while running reads both bits set
// - Transmit request self-clears on done/abort
// - Writing zero to transmit request ignored
// - Repeated DMA code, no reload: complete now; code completes only if that write also sets transmit request
// - Page, abort, halt bits always writable
// - DMA top bit aborts running DMA
// - Abort keeps advanced remote address
// - Reset flag set on reset, clear on start
// - Four index lines pick one of sixteen
module nic_command_register (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [3:0] reg_index_lines,
  input wire logic [7:0] host_wdata,
  input wire logic rx_busy,
  input wire logic tx_busy,
  input wire logic tx_done,
  input wire logic tx_abort,
  input wire logic rdma_count_reloaded,
  input wire logic rdma_count_zero,
  output logic [7:0] host_rdata,
  output logic host_rdata_valid,
  output logic [7:0] core_command,
  output logic reset_status,
  output logic core_active,
  output logic tx_start,
  output logic rdma_start_read,
  output logic rdma_start_write,
  output logic rdma_start_send,
  output logic rdma_abort_pulse,
  output logic rdma_complete,
  output logic [3:0] sel_index,
  output logic [1:0] sel_page,
  output logic sel_rd,
  output logic sel_wr
);

  nic_cmd_pkg::core_command_t cmd;
  nic_cmd_pkg::core_command_t next_cmd;
  nic_cmd_pkg::core_state_t state;
  nic_cmd_pkg::core_state_t next_state;
  nic_cmd_pkg::dma_state_t dma;
  nic_cmd_pkg::dma_state_t next_dma;
  nic_cmd_pkg::host_access_t access;
  logic next_reset_status;
  logic [7:0] next_host_rdata;
  logic next_host_rdata_valid;
  logic next_tx_start;
  logic next_rd_read;
  logic next_rd_write;
  logic next_rd_send;
  logic next_rd_abort;
  logic next_rd_complete;
  logic cmd_write;
  logic [2:0] wr_rdma;
  logic repeat_dma;

  always_comb begin
    access.cs = host_cs;
    access.wr = host_wr;
    access.rd = host_rd;
    access.index = reg_index_lines;
    access.wdata = host_wdata;
  end

  always_comb begin
    cmd_write = host_cs && host_wr &&
      reg_index_lines == nic_cmd_pkg::core_command_index;
    wr_rdma = host_wdata[nic_cmd_pkg::rdma_lsb +: 3];
    next_cmd = cmd;
    next_state = state;
    next_dma = dma;
    next_reset_status = reset_status;
    next_tx_start = 1'b0;
    next_rd_read = 1'b0;
    next_rd_write = 1'b0;
    next_rd_send = 1'b0;
    next_rd_abort = 1'b0;
    next_rd_complete = 1'b0;
    repeat_dma = 1'b0;
    // Transmit request drops itself; a new request below still wins.
    if (cmd.transmit_request && (tx_done || tx_abort)) begin
      next_cmd.transmit_request = 1'b0;
    end
    if (dma != nic_cmd_pkg::dma_idle && rdma_count_zero) begin
      next_dma = nic_cmd_pkg::dma_idle;
      next_rd_complete = 1'b1;
    end
    if (cmd_write) begin
      // Page, abort and halt bits are taken whatever else is busy.
      next_cmd.page = nic_cmd_pkg::page_t'(
        host_wdata[nic_cmd_pkg::page_lsb +: 2]);
      next_cmd.rdma_cmd = wr_rdma;
      next_cmd.halt_bit = host_wdata[nic_cmd_pkg::halt_pos];
      // Halt keeps run readable as set; a clear needs an explicit write.
      next_cmd.run_bit = host_wdata[nic_cmd_pkg::run_pos] ||
        (host_wdata[nic_cmd_pkg::halt_pos] && cmd.run_bit);
      if (host_wdata[nic_cmd_pkg::txreq_pos]) begin
        next_cmd.transmit_request = 1'b1;
        next_tx_start = 1'b1;
      end
      if (wr_rdma[2]) begin
        if (dma != nic_cmd_pkg::dma_idle) begin
          next_rd_abort = 1'b1;
        end
        next_dma = nic_cmd_pkg::dma_idle;
      end else begin
        repeat_dma = host_wdata[nic_cmd_pkg::txreq_pos] &&
          dma != nic_cmd_pkg::dma_idle && wr_rdma[1:0] == dma;
        if (repeat_dma) begin
          if (!rdma_count_reloaded) begin
            next_dma = nic_cmd_pkg::dma_idle;
            next_rd_complete = 1'b1;
          end
        end else begin
          unique case (nic_cmd_pkg::rdma_code_t'(wr_rdma))
            nic_cmd_pkg::rdma_read: begin
              next_dma = nic_cmd_pkg::dma_reading;
              next_rd_read = 1'b1;
            end
            nic_cmd_pkg::rdma_write: begin
              next_dma = nic_cmd_pkg::dma_writing;
              next_rd_write = 1'b1;
            end
            nic_cmd_pkg::rdma_send: begin
              next_dma = nic_cmd_pkg::dma_sending;
              next_rd_send = 1'b1;
            end
            // Code zero is illegal and is simply ignored.
            default: begin
              next_dma = dma;
            end
          endcase
        end
      end
    end
    unique case (state)
      nic_cmd_pkg::core_reset: begin
        if (!next_cmd.halt_bit && next_cmd.run_bit) begin
          next_state = nic_cmd_pkg::core_running;
          next_reset_status = 1'b0;
        end
      end
      nic_cmd_pkg::core_running: begin
        if (next_cmd.halt_bit) begin
          next_state = nic_cmd_pkg::core_draining;
        end
      end
      nic_cmd_pkg::core_draining: begin
        if (!rx_busy && !tx_busy) begin
          next_state = nic_cmd_pkg::core_reset;
          next_reset_status = 1'b1;
        end
      end
      default: begin
        next_state = nic_cmd_pkg::core_reset;
      end
    endcase
    next_host_rdata = 8'h00;
    next_host_rdata_valid = host_cs && host_rd &&
      reg_index_lines == nic_cmd_pkg::core_command_index;
    if (next_host_rdata_valid) begin
      next_host_rdata = cmd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd <= nic_cmd_pkg::command_reset_value;
      state <= nic_cmd_pkg::core_reset;
      dma <= nic_cmd_pkg::dma_idle;
      reset_status <= 1'b1;
      host_rdata <= 8'h00;
      host_rdata_valid <= 1'b0;
      core_command <= nic_cmd_pkg::command_reset_value;
      core_active <= 1'b0;
      tx_start <= 1'b0;
      rdma_start_read <= 1'b0;
      rdma_start_write <= 1'b0;
      rdma_start_send <= 1'b0;
      rdma_abort_pulse <= 1'b0;
      rdma_complete <= 1'b0;
    end else begin
      cmd <= next_cmd;
      state <= next_state;
      dma <= next_dma;
      reset_status <= next_reset_status;
      host_rdata <= next_host_rdata;
      host_rdata_valid <= next_host_rdata_valid;
      core_command <= next_cmd;
      core_active <= next_state != nic_cmd_pkg::core_reset;
      tx_start <= next_tx_start;
      rdma_start_read <= next_rd_read;
      rdma_start_write <= next_rd_write;
      rdma_start_send <= next_rd_send;
      rdma_abort_pulse <= next_rd_abort;
      rdma_complete <= next_rd_complete;
    end
  end

  page_decode u_page_decode (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .page(cmd.page),
    .access(access),
    .sel_index(sel_index),
    .sel_page(sel_page),
    .sel_rd(sel_rd),
    .sel_wr(sel_wr)
  );

endmodule // nic_command_register
`default_nettype wire

// [bench/nic_cmd_props.sv]
`timescale 1ns/100ps
`default_nettype none
module nic_cmd_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [3:0] reg_index_lines,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_valid,
  input wire logic [7:0] core_command,
  input wire logic reset_status,
  input wire logic core_active,
  input wire logic tx_start,
  input wire logic rdma_start_read,
  input wire logic rdma_start_write,
  input wire logic rdma_start_send,
  input wire logic rdma_abort_pulse
);
  logic wcmd;
  logic wr_q;
  logic [7:0] wd_q;
  assign wcmd = host_cs && host_wr && reg_index_lines == 4'h0;
  // The write is kept one cycle so each answer is tied to its cause.
  always_ff @(posedge ref_clk) begin
    wr_q <= rst_n && wcmd;
    wd_q <= host_wdata;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_tx_start: assert property (wcmd && host_wdata[2] |=> tx_start)
    else $error("no transmit start");
  a_tx_zero: assert property (wcmd && !host_wdata[2] |=> !tx_start)
    else $error("transmit start on zero");
  a_page_write: assert property (
    wcmd |=> core_command[7:6] == wd_q[7:6])
    else $error("page bits not taken");
  a_dma_read: assert property (
    rdma_start_read |-> wr_q && wd_q[5:3] == 3'h1)
    else $error("stray read start");
  a_dma_write: assert property (
    rdma_start_write |-> wr_q && wd_q[5:3] == 3'h2)
    else $error("stray write start");
  a_dma_send: assert property (
    rdma_start_send |-> wr_q && wd_q[5:3] == 3'h3)
    else $error("stray send start");
  a_dma_abort: assert property (rdma_abort_pulse |-> wr_q && wd_q[5])
    else $error("stray abort");
  a_halt_keeps: assert property (
    wcmd && host_wdata[0] && core_command[1] |=> core_command[1:0] == 2'h3)
    else $error("halt did not keep run");
  a_start_cause: assert property ($rose(core_active)
    |-> wr_q && wd_q[1:0] == 2'h2)
    else $error("core started without start");
  a_read_back: assert property (
    host_cs && host_rd && reg_index_lines == 4'h0
    |=> host_rdata_valid && host_rdata == $past(core_command))
    else $error("bad command read");
  a_flag_set: assert property (
    $rose(reset_status) |-> !core_active)
    else $error("flag set while active");
  c_tx: cover property (tx_start);
  c_abort: cover property (rdma_abort_pulse);
  c_halt: cover property ($fell(core_active));
endmodule // nic_cmd_props
`default_nettype wire

// [bench/host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic ref_clk,
  output nic_cmd_pkg::host_access_t acc
);
  initial acc = '0;
  // One single-cycle access per call; released at the next edge, so
  // back-to-back calls never drive the strobe twice in one step.
  task automatic access(input logic w, input logic [3:0] i,
      input logic [7:0] d);
    @(posedge ref_clk);
    acc <= '{cs: 1'b1, wr: w, rd: !w, index: i, wdata: d};
    @(posedge ref_clk);
    acc <= '0;
  endtask
endmodule // host_model
`default_nettype wire

// [bench/tb_nic_command_register.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_nic_command_register;
  logic ref_clk, rst_n, rx_busy, tx_busy, tx_done, tx_abort, rel, zero;
  logic rv, rs, act, txs, srd, swr, ssd, ab, cpl, s_rd, s_wr;
  logic [7:0] rdata, cmd, stat;
  logic [3:0] sidx;
  logic [1:0] spg;
  int err_count, n_tests;
  nic_cmd_pkg::host_access_t acc;
  assign stat = {rs, act, txs, srd, swr, ssd, ab, cpl};
  host_model host (.ref_clk(ref_clk), .acc(acc));
  nic_command_register uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .host_cs(acc.cs), .host_wr(acc.wr), .host_rd(acc.rd),
    .reg_index_lines(acc.index), .host_wdata(acc.wdata), .rx_busy(rx_busy),
    .tx_busy(tx_busy), .tx_done(tx_done), .tx_abort(tx_abort),
    .rdma_count_reloaded(rel), .rdma_count_zero(zero), .host_rdata(rdata),
    .host_rdata_valid(rv), .core_command(cmd), .reset_status(rs),
    .core_active(act), .tx_start(txs), .rdma_start_read(srd),
    .rdma_start_write(swr), .rdma_start_send(ssd), .rdma_abort_pulse(ab),
    .rdma_complete(cpl), .sel_index(sidx), .sel_page(spg), .sel_rd(s_rd),
    .sel_wr(s_wr));
  function automatic logic [7:0] cv(input logic [1:0] p, input logic [2:0] c,
      input logic t);
    return {p, c, t, 2'h2};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic op(input logic w, input logic [3:0] i, input logic [7:0] d,
      input logic [7:0] ec, input logic [7:0] es);
    host.access(w, i, d);
    #1;
    chk("command", ec, cmd);
    chk("status", es, stat);
  endtask
  task automatic done_pulse(input logic ab);
    @(posedge ref_clk) {tx_done, tx_abort} <= {!ab, ab};
    @(posedge ref_clk) {tx_done, tx_abort} <= 2'h0;
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
  initial begin
    logic [1:0] p;
    logic [3:0] i;
    logic w;
    {rst_n, rx_busy, tx_busy, tx_done, tx_abort, rel, zero} = '0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'hEE5F));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    op(1'b0, 4'h0, 8'h00, 8'h21, 8'h80);
    chk("read data", 8'h21, rdata);
    chk("read valid", 8'h01, {7'h00, rv});
    op(1'b1, 4'h0, 8'h22, 8'h22, 8'h40);
    op(1'b1, 4'h0, 8'h26, 8'h26, 8'h60);
    op(1'b0, 4'h0, 8'h00, 8'h26, 8'h40);
    chk("live read", 8'h26, rdata);
    op(1'b1, 4'h0, 8'h22, 8'h26, 8'h40);
    done_pulse(1'b0);
    chk("self clear", 8'h22, cmd);
    $display("test transmit done");
    for (int c = 1; c < 4; c++) begin
      op(1'b1, 4'h0, cv(2'h0, 3'(c), 1'b0), cv(2'h0, 3'(c), 1'b0),
         8'h40 | (8'h20 >> c));
      op(1'b1, 4'h0, 8'h22, 8'h22, 8'h42);
    end
    $display("test remote codes done");
    repeat (8) begin
      p = 2'($urandom % 4);
      i = 4'($urandom_range(15, 1));
      w = 1'($urandom);
      op(1'b1, 4'h0, cv(p, 3'h4, 1'b0), cv(p, 3'h4, 1'b0),
         8'h40);
      op(w, i, 8'($urandom), cv(p, 3'h4, 1'b0), 8'h40);
      chk("forward", {!w, w, p, i}, {s_rd, s_wr, spg, sidx});
    end
    $display("test pages done");
    op(1'b1, 4'h0, 8'h0A, 8'h0A, 8'h50);
    op(1'b1, 4'h0, 8'h0E, 8'h0E, 8'h61);
    done_pulse(1'b1);
    chk("abort clear", 8'h0A, cmd);
    op(1'b1, 4'h0, 8'h0A, 8'h0A, 8'h50);
    @(posedge ref_clk) rel <= 1'b1;
    op(1'b1, 4'h0, 8'h0E, 8'h0E, 8'h60);
    @(posedge ref_clk) {rel, zero} <= 2'h1;
    @(posedge ref_clk) zero <= 1'b0;
    #1;
    chk("count zero", 8'h41, stat);
    done_pulse(1'b0);
    op(1'b1, 4'h0, 8'h22, 8'h22, 8'h40);
    $display("test overlap done");
    @(posedge ref_clk) {rx_busy, tx_busy} <= 2'h3;
    op(1'b1, 4'h0, 8'h23, 8'h23, 8'h40);
    @(posedge ref_clk) tx_busy <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("rx drain", 8'h40, stat);
    @(posedge ref_clk) rx_busy <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("drained", 8'h80, stat);
    op(1'b1, 4'h0, 8'h23, 8'h23, 8'h80);
    op(1'b1, 4'h0, 8'h22, 8'h22, 8'h40);
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk("rereset", 8'h21, cmd);
    chk("rereset status", 8'h80, stat);
    $display("test halt done");
    stop_test();
  end
endmodule // tb_nic_command_register
bind nic_command_register nic_cmd_props chk (.*);
`default_nettype wire
